/* File: dv/lis_board.sv */
`timescale 1ns/1ps
// board side: gp pads with external levels, and a tiny serial memory
module lis_board (
  input wire logic [7:0] ext_level,
  input wire logic [7:0] gpio_out,
  input wire logic [7:0] gpio_oe,
  output logic [7:0] gpio_in,
  input wire logic eeprom_chip_select,
  input wire logic eeprom_clk,
  input wire logic eeprom_data_in,
  output logic eeprom_data_out
);
  logic do_r = 1'b0;
  // pad level
  // a pad that nobody drives shows the board's pull level, not the last value
  assign gpio_in = (gpio_oe & gpio_out) | (~gpio_oe & ext_level);
  always @(posedge eeprom_clk) begin
    do_r <= eeprom_data_in;
  end
  // data-out is released when deselected and the pull-up wins
  assign eeprom_data_out = eeprom_chip_select ? do_r : 1'b1;
endmodule

/* File: dv/tb.sv */
`timescale 1ns/1ps
module tb;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic pready, pslverr;
  logic mode = 1'b0;
  logic [7:0] types = 8'h00;
  logic [1:0] tsel = 2'h0;
  logic [3:0] urts = 4'h5;
  logic [3:0] udtr = 4'h3;
  logic [3:0] busy = 4'h0;
  logic [3:0] rts_o, dtr_o, de_o, re_o;
  logic [7:0] ext_level = 8'h3c;
  logic [7:0] g_in, g_out, g_oe;
  logic ee_cs, ee_clk, ee_di, ee_do;
  int failures = 0;
  int checked = 0;
  int cyc = 0;

  always #5 pclk = ~pclk;

  lis_top i_lis_top (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .all_ports_mode(mode), .port0_line_type_sel(types[1:0]),
    .port1_line_type_sel(types[3:2]), .port2_line_type_sel(types[5:4]),
    .port3_line_type_sel(types[7:6]), .auto_toggle_source_sel(tsel), .uart_rts_n(urts),
    .uart_dtr_n(udtr), .uart_tx_busy(busy), .request_to_send_n(rts_o),
    .terminal_ready_n(dtr_o), .driver_enable_out(de_o), .receiver_enable_out_n(re_o),
    .gpio_in(g_in), .gpio_out(g_out), .gpio_oe(g_oe), .eeprom_chip_select(ee_cs),
    .eeprom_clk(ee_clk), .eeprom_data_in(ee_di), .eeprom_data_out(ee_do));

  lis_board i_lis_board (.ext_level(ext_level), .gpio_out(g_out), .gpio_oe(g_oe),
    .gpio_in(g_in), .eeprom_chip_select(ee_cs), .eeprom_clk(ee_clk),
    .eeprom_data_in(ee_di), .eeprom_data_out(ee_do));

  task automatic report_and_stop();
    if (failures == 0 && checked > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  // a hung handshake ends the run through the same report
  always @(posedge pclk) begin
    cyc <= cyc + 1;
    if (cyc == 4000) begin
      failures++;
      report_and_stop();
    end
  end

  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      failures++;
      $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  // setup cycle, then access held until pready is seen high at an edge
  task automatic apb(input logic [7:0] a, input logic w, input logic [31:0] d,
                     output logic [31:0] q, output logic e);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    // only the bench timeout ends a wait that never sees pready
    while (pready !== 1'b1) begin
      @(posedge pclk);
    end
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    logic e;
    apb(a, 1'b1, d, q, e);
  endtask

  task automatic rd(input string nm, input logic [7:0] a, input logic [31:0] x,
                    input logic ex);
    logic [31:0] q;
    logic e;
    apb(a, 1'b0, 32'h0, q, e);
    chk(nm, q, x);
    chk({nm, " err"}, {31'h0, e}, {31'h0, ex});
  endtask

  // straps only move with the board idle; the decode settles within 4 edges
  task automatic straps(input logic m, input logic [7:0] t, input logic [1:0] s);
    mode <= m;
    types <= t;
    tsel <= s;
    repeat (6) @(posedge pclk);
  endtask

  task automatic t_reset();
    chk("gp oe pins", g_oe, 32'h0);
    chk("gp out pins", g_out, 32'h0);
    rd("gp oe reg", lis_pkg::LIS_OFF_GP_OE, 32'h0, 1'b0);
    rd("gp out reg", lis_pkg::LIS_OFF_GP_OUT, 32'h0, 1'b0);
    rd("eeprom reg", lis_pkg::LIS_OFF_EEPROM, 32'h8, 1'b0);
  endtask

  // strap low: port0 pair rules all four, other pairs only shown
  task automatic t_shared();
    for (int v = 0; v < 3; v++) begin
      straps(1'b0, {6'b011000, v[1:0]}, 2'h0);
      rd("types shared", lis_pkg::LIS_OFF_STATUS, {24'h0, {4{v[1:0]}}}, 1'b0);
      rd("info a", lis_pkg::LIS_OFF_INFO_A, {26'h0, v[1:0], 4'h0}, 1'b0);
      rd("info b", lis_pkg::LIS_OFF_INFO_B, 32'h0000_0600, 1'b0);
    end
  endtask

  task automatic t_per_port(input logic [7:0] t);
    straps(1'b1, t, 2'h1);
    rd("types own", lis_pkg::LIS_OFF_STATUS, {21'h0, 3'b101, t}, 1'b0);
    rd("info a own", lis_pkg::LIS_OFF_INFO_A, {26'h0, t[1:0], 4'h0}, 1'b0);
    rd("info b own", lis_pkg::LIS_OFF_INFO_B, {20'h0, t[7:4], 2'h0, t[3:2], 4'h0},
       1'b0);
  endtask

  // port0 plain line, ports 1..3 differential, so mask 1110 toggles
  task automatic t_toggle();
    logic [3:0] m, b, xr, xd, xe;
    m = 4'he;
    for (int s = 0; s < 4; s++) begin
      for (int k = 0; k < 2; k++) begin
        b = k ? 4'h9 : 4'h6;
        busy <= b;
        straps(1'b1, 8'h64, s[1:0]);
        xr = (s == 0) ? ((urts & ~m) | (~b & m)) : urts;
        xd = (s == 1) ? ((udtr & ~m) | (~b & m)) : udtr;
        xe = (s == 2) ? (b & m) : 4'h0;
        chk("rts out", rts_o, xr);
        chk("dtr out", dtr_o, xd);
        chk("drv en", de_o, xe);
        chk("rcv en n", re_o, xe);
      end
      rd("toggle sel", lis_pkg::LIS_OFF_STATUS, {21'h0, 1'b1, s[1:0], 8'h64}, 1'b0);
    end
  endtask

  task automatic t_gpio();
    wr(lis_pkg::LIS_OFF_GP_OE, 32'hffff_ff0f);
    wr(lis_pkg::LIS_OFF_GP_OUT, 32'h0000_00a5);
    chk("gp oe pins", g_oe, 32'h0f);
    chk("gp out pins", g_out, 32'ha5);
    rd("gp oe back", lis_pkg::LIS_OFF_GP_OE, 32'h0f, 1'b0);
    repeat (3) @(posedge pclk);
    wr(lis_pkg::LIS_OFF_GP_IN, 32'hffff_ffff);
    rd("gp in", lis_pkg::LIS_OFF_GP_IN, 32'h35, 1'b0);
  endtask

  task automatic t_eeprom();
    wr(lis_pkg::LIS_OFF_EEPROM, 32'h5);
    chk("ee pins", {ee_di, ee_clk, ee_cs}, 32'h5);
    wr(lis_pkg::LIS_OFF_EEPROM, 32'h7);
    wr(lis_pkg::LIS_OFF_EEPROM, 32'h1);
    wr(lis_pkg::LIS_OFF_EEPROM, 32'h3);
    repeat (3) @(posedge pclk);
    rd("ee low", lis_pkg::LIS_OFF_EEPROM, 32'h3, 1'b0);
    wr(lis_pkg::LIS_OFF_EEPROM, 32'h0);
    repeat (3) @(posedge pclk);
    rd("ee idle", lis_pkg::LIS_OFF_EEPROM, 32'h8, 1'b0);
  endtask

  // unmapped place errors and stores nothing; read-only status ignores writes
  task automatic t_refuse();
    wr(8'h20, 32'hffff_ffff);
    rd("unmapped", 8'h20, 32'h0, 1'b1);
    wr(lis_pkg::LIS_OFF_STATUS, 32'h0);
    rd("status ro", lis_pkg::LIS_OFF_STATUS, {21'h0, 3'b111, 8'h64}, 1'b0);
    rd("gp oe kept", lis_pkg::LIS_OFF_GP_OE, 32'h0f, 1'b0);
  endtask

  // a pair strapped 11 is unsupported and must never toggle its lines
  task automatic t_bad_type();
    busy <= 4'hf;
    straps(1'b1, 8'he4, 2'h2);
    chk("bad type drv en", de_o, 32'h6);
    chk("bad type rcv en n", re_o, 32'h6);
    chk("bad type rts", rts_o, 32'h5);
    rd("bad type status", lis_pkg::LIS_OFF_STATUS, {21'h0, 3'b110, 8'he4}, 1'b0);
  endtask

  // reset again with the strap high: registers fall back, straps are taken anew
  task automatic t_mid_reset();
    presetn <= 1'b0;
    repeat (2) @(posedge pclk);
    chk("gp oe in reset", g_oe, 32'h0);
    chk("drv en in reset", de_o, 32'h0);
    presetn <= 1'b1;
    repeat (4) @(posedge pclk);
    rd("gp oe after reset", lis_pkg::LIS_OFF_GP_OE, 32'h0, 1'b0);
    rd("types after reset", lis_pkg::LIS_OFF_STATUS, {21'h0, 3'b110, 8'he4}, 1'b0);
  endtask

  initial begin
    repeat (5) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    t_reset();
    t_shared();
    t_per_port(8'h61);
    t_per_port(8'h86);
    t_toggle();
    t_gpio();
    t_eeprom();
    t_refuse();
    t_bad_type();
    t_mid_reset();
    report_and_stop();
  end
endmodule

/* File: hdl/lis_pkg.sv */
package lis_pkg;

  // line transceiver codes carried on every interface-select pair
  typedef enum logic [1:0] {
    LIS_RS232 = 2'h0,
    LIS_RS422 = 2'h1,
    LIS_RS485 = 2'h2,
    LIS_RSBAD = 2'h3
  } lis_line_t;

  // auto-toggle source codes
  typedef enum logic [1:0] {
    LIS_TGL_RTS = 2'h0,
    LIS_TGL_DTR = 2'h1,
    LIS_TGL_DED = 2'h2,
    LIS_TGL_OFF = 2'h3
  } lis_tgl_t;

  localparam int LIS_NPORT = 4;
  localparam int LIS_NGPIO = 8;
  localparam int LIS_SYNC_STAGES = 2;

  // register byte offsets
  localparam logic [7:0] LIS_OFF_INFO_A = 8'h00;
  localparam logic [7:0] LIS_OFF_INFO_B = 8'h04;
  localparam logic [7:0] LIS_OFF_GP_OE = 8'h08;
  localparam logic [7:0] LIS_OFF_GP_OUT = 8'h0c;
  localparam logic [7:0] LIS_OFF_GP_IN = 8'h10;
  localparam logic [7:0] LIS_OFF_STATUS = 8'h14;
  localparam logic [7:0] LIS_OFF_EEPROM = 8'h18;

  // field positions
  localparam int LIS_INFO_SEL_LSB = 4;
  localparam int LIS_INFO_P2_LSB = 8;
  localparam int LIS_INFO_P3_LSB = 10;
  localparam int LIS_ST_TYPES_LSB = 0;
  localparam int LIS_ST_TGL_LSB = 8;
  localparam int LIS_ST_ALL_BIT = 10;
  localparam int LIS_EE_CS_BIT = 0;
  localparam int LIS_EE_SK_BIT = 1;
  localparam int LIS_EE_DI_BIT = 2;
  localparam int LIS_EE_DO_BIT = 3;

  // reset values
  localparam logic [7:0] LIS_GP_OE_RST = 8'h00;
  localparam logic [7:0] LIS_GP_OUT_RST = 8'h00;
  localparam logic [2:0] LIS_EE_RST = 3'h0;

endpackage

/* File: hdl/lis_sync.sv */
`timescale 1ns/1ps
module lis_sync #(
  parameter int W = 1
) (
  input wire logic pclk,
  input wire logic presetn,
  lis_sync_if.stage s
);

  logic [W-1:0] meta_r;
  logic [W-1:0] hold_r;

  // two-flop crossing; meta_r feeds hold_r only
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      meta_r <= '0;
      hold_r <= '0;
    end else begin
      meta_r <= s.raw;
      hold_r <= meta_r;
    end
  end

  assign s.sync = hold_r;

endmodule

/* File: hdl/lis_sync_if.sv */
`timescale 1ns/1ps
interface lis_sync_if #(
  parameter int W = 1
);
  logic [W-1:0] raw;
  logic [W-1:0] sync;
  modport user (output raw, input sync);
  modport stage (input raw, output sync);
endinterface

/* File: hdl/lis_top.sv */
`timescale 1ns/1ps
// Behaviour
// (RULE_01) per-port line types are independent only while all-ports strap is high
// (RULE_02) strap low: port0 select pair sets the type of all four ports
// (RULE_03) select 00 RS232, 01 RS422, 10 RS485; 11 unsupported
// (RULE_04) strap high: port0 select pair sets only port0
// (RULE_05) strap high: port1 type from its own select pair
// (RULE_06) strap high: port2 type from its own select pair
// (RULE_07) strap high: port3 type from its own select pair
// (RULE_08) port0 select pins readable in info register a bits 5:4
// (RULE_09) port1 select pins readable in info register b bits 5:4
// (RULE_10) toggle select picks rts, dtr or dedicated enables as toggle signal
// (RULE_11) auto toggling only on RS422 or RS485 ports, never RS232
// (RULE_12) eight gp pins with output-enable, output-value and input registers
// (RULE_13) drive eeprom chip select, clock, data-in; receive its data-out
// (RULE_14) straps and gp inputs synchronised before decode or readback
module lis_top #(
  parameter int NUM_GPIO = lis_pkg::LIS_NGPIO
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic all_ports_mode,
  input wire logic [1:0] port0_line_type_sel,
  input wire logic [1:0] port1_line_type_sel,
  input wire logic [1:0] port2_line_type_sel,
  input wire logic [1:0] port3_line_type_sel,
  input wire logic [1:0] auto_toggle_source_sel,
  input wire logic [3:0] uart_rts_n,
  input wire logic [3:0] uart_dtr_n,
  input wire logic [3:0] uart_tx_busy,
  output logic [3:0] request_to_send_n,
  output logic [3:0] terminal_ready_n,
  output logic [3:0] driver_enable_out,
  output logic [3:0] receiver_enable_out_n,
  input wire logic [NUM_GPIO-1:0] gpio_in,
  output logic [NUM_GPIO-1:0] gpio_out,
  output logic [NUM_GPIO-1:0] gpio_oe,
  output logic eeprom_chip_select,
  output logic eeprom_clk,
  output logic eeprom_data_in,
  input wire logic eeprom_data_out
);

  localparam int NP = lis_pkg::LIS_NPORT;
  localparam int SW = 1 + 2 * NP + 2 + NUM_GPIO + 1;

  // elaboration guard: every gp field is at most one byte wide in its register
  if (NUM_GPIO < 1 || NUM_GPIO > 8) begin : g_gpio_check
    $error("lis_top: NUM_GPIO must be 1..8");
  end

  // strap and gp input crossing
  lis_sync_if #(.W(SW)) sif ();
  // (RULE_14) sync before use
  assign sif.raw = {eeprom_data_out, gpio_in, auto_toggle_source_sel, port3_line_type_sel,
                    port2_line_type_sel, port1_line_type_sel, port0_line_type_sel,
                    all_ports_mode};
  lis_sync #(.W(SW)) u_sync (
    .pclk(pclk),
    .presetn(presetn),
    .s(sif.stage)
  );

  logic all_q;
  logic [1:0] sel_q [NP];
  logic [1:0] tgl_q;
  logic [NUM_GPIO-1:0] gpin_q;
  logic ee_do_q;

  assign all_q = sif.sync[0];
  assign tgl_q = sif.sync[2*NP+2:2*NP+1];
  assign gpin_q = sif.sync[2*NP+2+NUM_GPIO:2*NP+3];
  assign ee_do_q = sif.sync[SW-1];

  // decoded line type per port, one flop after the crossing
  lis_pkg::lis_line_t line_type_r [NP];
  logic [NP-1:0] toggle_ok;

  genvar gp;
  generate
    for (gp = 0; gp < NP; gp++) begin : g_port
      assign sel_q[gp] = sif.sync[2*gp+2:2*gp+1];
      // (RULE_11) only differential types toggle; 11 is treated as no toggle
      assign toggle_ok[gp] = (line_type_r[gp] == lis_pkg::LIS_RS422) ||
                             (line_type_r[gp] == lis_pkg::LIS_RS485);

      // (RULE_01) global or per-port type
      // (RULE_02) (RULE_04) (RULE_05) (RULE_06) (RULE_07) select source pair
      // (RULE_03) two-bit code decode
      always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          line_type_r[gp] <= lis_pkg::LIS_RS232;
        end else if (all_q) begin
          line_type_r[gp] <= lis_pkg::lis_line_t'(sel_q[gp]);
        end else begin
          line_type_r[gp] <= lis_pkg::lis_line_t'(sel_q[0]);
        end
      end

      // (RULE_10) toggle source steering, registered so pins never glitch
      always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          request_to_send_n[gp] <= 1'b1;
          terminal_ready_n[gp] <= 1'b1;
          driver_enable_out[gp] <= 1'b0;
          receiver_enable_out_n[gp] <= 1'b0;
        end else begin
          request_to_send_n[gp] <= uart_rts_n[gp];
          terminal_ready_n[gp] <= uart_dtr_n[gp];
          driver_enable_out[gp] <= 1'b0;
          receiver_enable_out_n[gp] <= 1'b0;
          if (toggle_ok[gp]) begin
            case (lis_pkg::lis_tgl_t'(tgl_q))
              lis_pkg::LIS_TGL_RTS: request_to_send_n[gp] <= !uart_tx_busy[gp];
              lis_pkg::LIS_TGL_DTR: terminal_ready_n[gp] <= !uart_tx_busy[gp];
              lis_pkg::LIS_TGL_DED: begin
                driver_enable_out[gp] <= uart_tx_busy[gp];
                receiver_enable_out_n[gp] <= uart_tx_busy[gp];
              end
              default: begin
              end
            endcase
          end
        end
      end
    end
  endgenerate

  // apb decode; zero wait states, so pready is a plain constant high
  logic setup_ph;
  logic access_ph;
  logic addr_ok;
  logic wr_en;
  assign setup_ph = psel && !penable;
  assign access_ph = psel && penable;
  assign addr_ok = (paddr == lis_pkg::LIS_OFF_INFO_A) || (paddr == lis_pkg::LIS_OFF_INFO_B) ||
                   (paddr == lis_pkg::LIS_OFF_GP_OE) || (paddr == lis_pkg::LIS_OFF_GP_OUT) ||
                   (paddr == lis_pkg::LIS_OFF_GP_IN) || (paddr == lis_pkg::LIS_OFF_STATUS) ||
                   (paddr == lis_pkg::LIS_OFF_EEPROM);
  assign wr_en = access_ph && pwrite && addr_ok;
  assign pready = 1'b1;
  assign pslverr = access_ph && !addr_ok;

  logic [NUM_GPIO-1:0] gp_output_enable_reg_r;
  logic [NUM_GPIO-1:0] gp_output_value_reg_r;
  logic [2:0] eeprom_ctrl_r;

  // (RULE_12) gp direction and value registers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      gp_output_enable_reg_r <= lis_pkg::LIS_GP_OE_RST[NUM_GPIO-1:0];
      gp_output_value_reg_r <= lis_pkg::LIS_GP_OUT_RST[NUM_GPIO-1:0];
    end else if (wr_en) begin
      if (paddr == lis_pkg::LIS_OFF_GP_OE) begin
        gp_output_enable_reg_r <= pwdata[NUM_GPIO-1:0];
      end
      if (paddr == lis_pkg::LIS_OFF_GP_OUT) begin
        gp_output_value_reg_r <= pwdata[NUM_GPIO-1:0];
      end
    end
  end
  assign gpio_oe = gp_output_enable_reg_r;
  assign gpio_out = gp_output_value_reg_r;

  // (RULE_13) eeprom pins bit-banged by software; loader lives elsewhere
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      eeprom_ctrl_r <= lis_pkg::LIS_EE_RST;
    end else if (wr_en && paddr == lis_pkg::LIS_OFF_EEPROM) begin
      eeprom_ctrl_r <= pwdata[lis_pkg::LIS_EE_DI_BIT:lis_pkg::LIS_EE_CS_BIT];
    end
  end
  assign eeprom_chip_select = eeprom_ctrl_r[lis_pkg::LIS_EE_CS_BIT];
  assign eeprom_clk = eeprom_ctrl_r[lis_pkg::LIS_EE_SK_BIT];
  assign eeprom_data_in = eeprom_ctrl_r[lis_pkg::LIS_EE_DI_BIT];

  // read mux; pins sampled at setup so data is stable through access
  logic [31:0] rd_nxt;
  always_comb begin
    rd_nxt = 32'h0;
    case (paddr)
      // (RULE_08) port0 pins in info a
      lis_pkg::LIS_OFF_INFO_A: rd_nxt[lis_pkg::LIS_INFO_SEL_LSB +: 2] = sel_q[0];
      // (RULE_09) port1 pins in info b; ports 2 and 3 placed above
      lis_pkg::LIS_OFF_INFO_B: begin
        rd_nxt[lis_pkg::LIS_INFO_SEL_LSB +: 2] = sel_q[1];
        rd_nxt[lis_pkg::LIS_INFO_P2_LSB +: 2] = sel_q[2];
        rd_nxt[lis_pkg::LIS_INFO_P3_LSB +: 2] = sel_q[3];
      end
      lis_pkg::LIS_OFF_GP_OE: rd_nxt[NUM_GPIO-1:0] = gp_output_enable_reg_r;
      lis_pkg::LIS_OFF_GP_OUT: rd_nxt[NUM_GPIO-1:0] = gp_output_value_reg_r;
      // (RULE_12) gp input readback
      lis_pkg::LIS_OFF_GP_IN: rd_nxt[NUM_GPIO-1:0] = gpin_q;
      lis_pkg::LIS_OFF_STATUS: begin
        for (int i = 0; i < NP; i++) begin
          rd_nxt[lis_pkg::LIS_ST_TYPES_LSB + 2*i +: 2] = line_type_r[i];
        end
        rd_nxt[lis_pkg::LIS_ST_TGL_LSB +: 2] = tgl_q;
        rd_nxt[lis_pkg::LIS_ST_ALL_BIT] = all_q;
      end
      lis_pkg::LIS_OFF_EEPROM: begin
        rd_nxt[lis_pkg::LIS_EE_DI_BIT:lis_pkg::LIS_EE_CS_BIT] = eeprom_ctrl_r;
        rd_nxt[lis_pkg::LIS_EE_DO_BIT] = ee_do_q;
      end
      default: rd_nxt = 32'h0;
    endcase
  end

  logic [31:0] prdata_r;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_r <= 32'h0;
    end else if (setup_ph && !pwrite) begin
      prdata_r <= rd_nxt;
    end
  end
  assign prdata = prdata_r;

  // checks; each but a_strap_sync ties a register to what its inputs showed one edge earlier (a_strap_sync looks two edges back)
  a_global_type: assert property (@(posedge pclk) disable iff (!presetn) // (RULE_02)
    !all_q |=> line_type_r[3] == $past(sel_q[0]))
    else $error("strap low: port3 type not from port0 pins");

  a_port0_type: assert property (@(posedge pclk) disable iff (!presetn) // (RULE_04)
    all_q |=> line_type_r[0] == $past(sel_q[0]))
    else $error("strap high: port0 type wrong");

  a_port1_own: assert property (@(posedge pclk) disable iff (!presetn) // (RULE_05)
    all_q |=> line_type_r[1] == $past(sel_q[1]))
    else $error("strap high: port1 type not from own pins");

  a_port2_own: assert property (@(posedge pclk) disable iff (!presetn) // (RULE_06)
    all_q |=> line_type_r[2] == $past(sel_q[2]))
    else $error("strap high: port2 type not from own pins");

  a_port3_own: assert property (@(posedge pclk) disable iff (!presetn) // (RULE_07)
    all_q |=> line_type_r[3] == $past(sel_q[3]))
    else $error("strap high: port3 type not from own pins");

  a_rs232_quiet: assert property (@(posedge pclk) disable iff (!presetn) // (RULE_11)
    (line_type_r[1] == lis_pkg::LIS_RS232) |=>
      driver_enable_out[1] == 1'b0 && request_to_send_n[1] == $past(uart_rts_n[1]))
    else $error("rs232 port toggled");

  a_bad_quiet: assert property (@(posedge pclk) disable iff (!presetn) // (RULE_03)
    (line_type_r[3] == lis_pkg::LIS_RSBAD) |=>
      driver_enable_out[3] == 1'b0 && receiver_enable_out_n[3] == 1'b0 &&
      request_to_send_n[3] == $past(uart_rts_n[3]) &&
      terminal_ready_n[3] == $past(uart_dtr_n[3]))
    else $error("unsupported line type toggled");

  a_ded_toggle: assert property (@(posedge pclk) disable iff (!presetn) // (RULE_10)
    (tgl_q == 2'h2 && line_type_r[0] == lis_pkg::LIS_RS485) |=>
      driver_enable_out[0] == $past(uart_tx_busy[0]) &&
      receiver_enable_out_n[0] == $past(uart_tx_busy[0]))
    else $error("dedicated enables not following transmit");

  a_rts_toggle: assert property (@(posedge pclk) disable iff (!presetn) // (RULE_10)
    (tgl_q == 2'h0 && line_type_r[2] == lis_pkg::LIS_RS422) |=>
      request_to_send_n[2] == !$past(uart_tx_busy[2]))
    else $error("rts not toggling on differential port");

  a_dtr_toggle: assert property (@(posedge pclk) disable iff (!presetn) // (RULE_10)
    (tgl_q == 2'h1 && line_type_r[1] == lis_pkg::LIS_RS422) |=>
      terminal_ready_n[1] == !$past(uart_tx_busy[1]))
    else $error("dtr not toggling on differential port");

  a_info_read: assert property (@(posedge pclk) disable iff (!presetn) // (RULE_08)
    (setup_ph && !pwrite && paddr == lis_pkg::LIS_OFF_INFO_A) |=>
      prdata[5:4] == $past(sel_q[0]))
    else $error("info a does not show port0 pins");

  a_info_b_read: assert property (@(posedge pclk) disable iff (!presetn) // (RULE_09)
    (setup_ph && !pwrite && paddr == lis_pkg::LIS_OFF_INFO_B) |=>
      prdata[5:4] == $past(sel_q[1]))
    else $error("info b does not show port1 pins");

  a_gp_write: assert property (@(posedge pclk) disable iff (!presetn) // (RULE_12)
    (wr_en && paddr == lis_pkg::LIS_OFF_GP_OE) |=>
      gpio_oe == $past(pwdata[NUM_GPIO-1:0]))
    else $error("gp output enable write lost");

  a_gp_out_write: assert property (@(posedge pclk) disable iff (!presetn) // (RULE_12)
    (wr_en && paddr == lis_pkg::LIS_OFF_GP_OUT) |=>
      gpio_out == $past(pwdata[NUM_GPIO-1:0]))
    else $error("gp output value write lost");

  a_eeprom_pins: assert property (@(posedge pclk) disable iff (!presetn) // (RULE_13)
    (wr_en && paddr == lis_pkg::LIS_OFF_EEPROM) |=>
      {eeprom_data_in, eeprom_clk, eeprom_chip_select} == $past(pwdata[2:0]))
    else $error("eeprom pins do not follow the control write");

  // the two edges after a release still show the flops' reset value, not the pin
  a_strap_sync: assert property (@(posedge pclk) disable iff (!presetn) // (RULE_14)
    $past(presetn, 2) |-> all_q == $past(all_ports_mode, 2))
    else $error("strap not two-flop synchronised");

endmodule
